/* File: irqfe_pkg.sv */
// package: offsets, field layout, reset values and carriers of the interrupt register set
package irqfe_pkg;

    // ==========================================================
    // register indices in special-purpose data memory
    localparam logic [2:0] IDX_EXT_EDGE_SELECT      = 3'h0;
    localparam logic [2:0] IDX_IRQ_CTRL_PINS_GLOBAL = 3'h1;
    localparam logic [2:0] IDX_IRQ_CTRL_PERIPH_A    = 3'h2;
    localparam logic [2:0] IDX_IRQ_CTRL_TIMER_MATCH = 3'h3;
    localparam logic [2:0] IDX_IRQ_CTRL_TIME_BASE   = 3'h4;

    // ==========================================================
    // implemented-bit masks; everything else reads zero
    localparam logic [7:0] MASK_EXT_EDGE_SELECT      = 8'h0F;
    localparam logic [7:0] MASK_IRQ_CTRL_PINS_GLOBAL = 8'h6D;
    localparam logic [7:0] MASK_IRQ_CTRL_PERIPH_A    = 8'hFF;
    localparam logic [7:0] MASK_IRQ_CTRL_TIMER_MATCH = 8'hFF;
    localparam logic [7:0] MASK_IRQ_CTRL_TIME_BASE   = 8'h33;

    // ==========================================================
    // reset values
    localparam logic [3:0] RST_EXT_EDGE_SELECT = 4'h0;
    localparam logic [7:0] RST_IRQ_CTRL        = 8'h00;
    localparam logic [7:0] RST_READ_DATA       = 8'h00;

    // ==========================================================
    // field positions
    localparam int POS_PIN_ZERO_EDGE_SEL = 0;
    localparam int POS_PIN_ONE_EDGE_SEL  = 2;
    localparam int POS_GLOBAL_IRQ_ENABLE = 0;
    localparam int POS_PIN_ZERO_ENABLE   = 2;
    localparam int POS_PIN_ONE_ENABLE    = 3;
    localparam int POS_PIN_ZERO_FLAG     = 5;
    localparam int POS_PIN_ONE_FLAG      = 6;
    localparam int POS_TIMEBASE_ZERO_EN  = 0;
    localparam int POS_TIMEBASE_ONE_EN   = 1;
    localparam int POS_TIMEBASE_ZERO_FLG = 4;
    localparam int POS_TIMEBASE_ONE_FLG  = 5;
    localparam int POS_NIBBLE_FLAGS      = 4;

    // ==========================================================
    // edge selector encoding
    typedef enum logic [1:0] {
        EDGE_OFF     = 2'b00,
        EDGE_RISING  = 2'b01,
        EDGE_FALLING = 2'b10,
        EDGE_BOTH    = 2'b11
    } irqfe_edge_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic       sel;
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } irqfe_sfr_req_t;

    // one-cycle event pulses, in flag order of their registers
    typedef struct packed {
        logic eeprom;
        logic converter;
        logic low_volt;
        logic serial_module;
        logic std_timer_a;
        logic std_timer_p;
        logic per_timer_a;
        logic per_timer_p;
        logic timebase_one;
        logic timebase_zero;
    } irqfe_evt_t;

    localparam int NUM_PENDING = 12;

endpackage

/* File: irqfe_edge_det.sv */
// external pin synchroniser and selectable edge detector
`timescale 1ns/1ps
`default_nettype none

module irqfe_edge_det (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // asynchronous pin
    input  wire logic                 pin_async,
    // edge selector
    input  wire irqfe_pkg::irqfe_edge_t edge_sel,
    // one-cycle request
    output logic                      edge_evt
);
    import irqfe_pkg::*;

    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic nxt_sync1;
    logic nxt_sync2;
    logic nxt_prev;
    logic rise;
    logic fall;

    // ==========================================================
    // synchroniser; only the second stage feeds logic
    always_comb begin
        nxt_sync1 = pin_async;
        nxt_sync2 = sync1_ff;
        nxt_prev  = sync2_ff;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            prev_ff  <= nxt_prev;
        end
    end

    // ==========================================================
    // edge selection
    always_comb begin
        rise = sync2_ff & ~prev_ff;
        fall = ~sync2_ff & prev_ff;
        // R1 selector decoding
        unique case (edge_sel)
            EDGE_OFF:     edge_evt = 1'b0;
            EDGE_RISING:  edge_evt = rise;
            EDGE_FALLING: edge_evt = fall;
            EDGE_BOTH:    edge_evt = rise | fall;
        endcase
    end

endmodule // irqfe_edge_det
`default_nettype wire

/* File: irqfe_regs.sv */
// interrupt flag and enable register set with edge-selected external pins
//
// Functional notes
// R1 - pin zero selector: off, rise, fall, both
// R2 - pin one selector, same code, bits 3:2
// R3 - edge register upper nibble reads zero
// R4 - pin zero edge sets its flag
// R5 - pin one edge sets its flag
// R6 - sources set flags, software writes enables
// R7 - four control registers plus edge register
// R8 - registers mix enables and request flags
// R9 - pinless variant: software keeps pin bits zero
// R10 - periph register: four flags, four enables
// R11 - timer register: four match flags, enables
// R12 - interrupt needs flag, enable, global enable
// R13 - reserved bits held and read zero
`timescale 1ns/1ps
`default_nettype none

module irqfe_regs (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // special-purpose data memory access
    input  wire irqfe_pkg::irqfe_sfr_req_t sfr_req,
    output logic [7:0]                     sfr_rdata,
    // external interrupt pins
    input  wire logic                      ext_pin_zero,
    input  wire logic                      ext_pin_one,
    // internal source events
    input  wire irqfe_pkg::irqfe_evt_t     src_evt,
    // requests to the core
    output logic [irqfe_pkg::NUM_PENDING-1:0] irq_pending,
    output logic                           irq_req
);
    import irqfe_pkg::*;

    logic [3:0] edge_ff;
    logic [7:0] pins_ff;
    logic [7:0] periph_ff;
    logic [7:0] timer_ff;
    logic [7:0] tbase_ff;
    logic [7:0] rdata_ff;
    logic [3:0] nxt_edge;
    logic [7:0] nxt_pins;
    logic [7:0] nxt_periph;
    logic [7:0] nxt_timer;
    logic [7:0] nxt_tbase;
    logic [7:0] nxt_rdata;
    logic [1:0] pin_evt;
    logic [1:0] pin_async;
    logic       wr_edge;
    logic       wr_pins;
    logic       wr_periph;
    logic       wr_timer;
    logic       wr_tbase;
    logic [7:0] set_pins;
    logic [7:0] set_periph;
    logic [7:0] set_timer;
    logic [7:0] set_tbase;

    // ==========================================================
    // external pin edge detection
    assign pin_async = {ext_pin_one, ext_pin_zero};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            // R1 R2 per-pin selector field
            irqfe_edge_det u_edge (
                .clk       (clk),
                .rst       (rst),
                .pin_async (pin_async[gi]),
                .edge_sel  (irqfe_edge_t'(edge_ff[2*gi +: 2])),
                .edge_evt  (pin_evt[gi])
            );
        end
    endgenerate

    // ==========================================================
    // write decode
    always_comb begin
        wr_edge   = sfr_req.sel & sfr_req.wr & (sfr_req.addr == IDX_EXT_EDGE_SELECT);
        wr_pins   = sfr_req.sel & sfr_req.wr & (sfr_req.addr == IDX_IRQ_CTRL_PINS_GLOBAL);
        wr_periph = sfr_req.sel & sfr_req.wr & (sfr_req.addr == IDX_IRQ_CTRL_PERIPH_A);
        wr_timer  = sfr_req.sel & sfr_req.wr & (sfr_req.addr == IDX_IRQ_CTRL_TIMER_MATCH);
        wr_tbase  = sfr_req.sel & sfr_req.wr & (sfr_req.addr == IDX_IRQ_CTRL_TIME_BASE);
    end

    // ==========================================================
    // hardware set vectors, placed on the flag bits
    always_comb begin
        set_pins                        = 8'h00;
        // R4 pin zero flag set
        set_pins[POS_PIN_ZERO_FLAG]     = pin_evt[0];
        // R5 pin one flag set
        set_pins[POS_PIN_ONE_FLAG]      = pin_evt[1];
        // R10 periph flag sets
        set_periph = {src_evt.eeprom, src_evt.converter, src_evt.low_volt,
                      src_evt.serial_module, 4'h0};
        // R11 timer match sets
        set_timer  = {src_evt.std_timer_a, src_evt.std_timer_p, src_evt.per_timer_a,
                      src_evt.per_timer_p, 4'h0};
        set_tbase                        = 8'h00;
        set_tbase[POS_TIMEBASE_ZERO_FLG] = src_evt.timebase_zero;
        set_tbase[POS_TIMEBASE_ONE_FLG]  = src_evt.timebase_one;
    end

    // ==========================================================
    // register next values
    // a set in the same cycle as a software clear wins, so no event is lost
    always_comb begin
        nxt_edge   = edge_ff;
        nxt_pins   = pins_ff;
        nxt_periph = periph_ff;
        nxt_timer  = timer_ff;
        nxt_tbase  = tbase_ff;
        // R3 upper nibble not stored
        if (wr_edge) begin
            nxt_edge = sfr_req.wdata[3:0] & MASK_EXT_EDGE_SELECT[3:0];
        end
        // R6 software owns the enables
        if (wr_pins) begin
            nxt_pins = sfr_req.wdata;
        end
        if (wr_periph) begin
            nxt_periph = sfr_req.wdata;
        end
        if (wr_timer) begin
            nxt_timer = sfr_req.wdata;
        end
        if (wr_tbase) begin
            nxt_tbase = sfr_req.wdata;
        end
        // R6 hardware sets flags
        nxt_pins   = nxt_pins | set_pins;
        nxt_periph = nxt_periph | set_periph;
        nxt_timer  = nxt_timer | set_timer;
        nxt_tbase  = nxt_tbase | set_tbase;
        // R13 reserved bits forced zero
        nxt_pins   = nxt_pins & MASK_IRQ_CTRL_PINS_GLOBAL;
        nxt_periph = nxt_periph & MASK_IRQ_CTRL_PERIPH_A;
        nxt_timer  = nxt_timer & MASK_IRQ_CTRL_TIMER_MATCH;
        nxt_tbase  = nxt_tbase & MASK_IRQ_CTRL_TIME_BASE;
    end

    // R7 five registers stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            edge_ff   <= RST_EXT_EDGE_SELECT;
            pins_ff   <= RST_IRQ_CTRL;
            periph_ff <= RST_IRQ_CTRL;
            timer_ff  <= RST_IRQ_CTRL;
            tbase_ff  <= RST_IRQ_CTRL;
        end else begin
            edge_ff   <= nxt_edge;
            pins_ff   <= nxt_pins;
            periph_ff <= nxt_periph;
            timer_ff  <= nxt_timer;
            tbase_ff  <= nxt_tbase;
        end
    end

    // ==========================================================
    // read path, registered; unmapped index reads zero
    always_comb begin
        nxt_rdata = rdata_ff;
        if (sfr_req.sel & sfr_req.rd) begin
            unique case (sfr_req.addr)
                // R3 upper nibble reads zero
                IDX_EXT_EDGE_SELECT:      nxt_rdata = {4'h0, edge_ff};
                IDX_IRQ_CTRL_PINS_GLOBAL: nxt_rdata = pins_ff;
                IDX_IRQ_CTRL_PERIPH_A:    nxt_rdata = periph_ff;
                IDX_IRQ_CTRL_TIMER_MATCH: nxt_rdata = timer_ff;
                IDX_IRQ_CTRL_TIME_BASE:   nxt_rdata = tbase_ff;
                default:                  nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= RST_READ_DATA;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign sfr_rdata = rdata_ff;

    // ==========================================================
    // request to the core
    // R8 flag paired with its enable
    always_comb begin
        irq_pending[0]   = pins_ff[POS_PIN_ZERO_FLAG] & pins_ff[POS_PIN_ZERO_ENABLE];
        irq_pending[1]   = pins_ff[POS_PIN_ONE_FLAG] & pins_ff[POS_PIN_ONE_ENABLE];
        irq_pending[5:2] = periph_ff[POS_NIBBLE_FLAGS +: 4] & periph_ff[3:0];
        irq_pending[9:6] = timer_ff[POS_NIBBLE_FLAGS +: 4] & timer_ff[3:0];
        irq_pending[10]  = tbase_ff[POS_TIMEBASE_ZERO_FLG] & tbase_ff[POS_TIMEBASE_ZERO_EN];
        irq_pending[11]  = tbase_ff[POS_TIMEBASE_ONE_FLG] & tbase_ff[POS_TIMEBASE_ONE_EN];
        // R12 gated by global enable
        irq_req = pins_ff[POS_GLOBAL_IRQ_ENABLE] & (|irq_pending);
    end

endmodule // irqfe_regs
`default_nettype wire

/* File: irqfe_regs_checker.sv */
// assertion checker for the interrupt flag and enable registers
`timescale 1ns/1ps
`default_nettype none
module irqfe_regs_checker (
    // clock and reset
    input wire logic                      clk,
    input wire logic                      rst,
    // bus, pins and sources
    input wire irqfe_pkg::irqfe_sfr_req_t sfr_req,
    input wire logic [7:0]                sfr_rdata,
    input wire logic                      ext_pin_zero,
    input wire logic                      ext_pin_one,
    input wire irqfe_pkg::irqfe_evt_t     src_evt,
    // requests
    input wire logic [11:0]               irq_pending,
    input wire logic                      irq_req
);
    import irqfe_pkg::*;
    logic wr_c;
    logic rd_c;
    logic evt_any;
    assign wr_c = sfr_req.sel & sfr_req.wr;
    assign rd_c = sfr_req.sel & sfr_req.rd;
    assign evt_any = |src_evt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // assertions
    AST_REQ_NEEDS_PEND: assert property (irq_req |-> |irq_pending)
        else $error("request without pending source");
    AST_REQ_FALL: assert property ($fell(irq_req) |-> $past(wr_c))
        else $error("request dropped without a write");
    AST_PEND_FALL: assert property (|($past(irq_pending) & ~irq_pending) |-> $past(wr_c))
        else $error("pending cleared without a write");
    AST_PEND_RISE: assert property (|(irq_pending[11:2] & ~$past(irq_pending[11:2]))
        |-> $past(wr_c) || $past(evt_any))
        else $error("pending set without cause");
    AST_RD_HOLD: assert property (!$past(rd_c) |-> $stable(sfr_rdata))
        else $error("read data moved without a read");
    AST_EDGE_HI_ZERO: assert property ($past(rd_c) && $past(sfr_req.addr) == 3'h0
        |-> sfr_rdata[7:4] == 4'h0)
        else $error("edge register upper nibble not zero");
    AST_PINS_RSVD: assert property ($past(rd_c) && $past(sfr_req.addr) == 3'h1
        |-> (sfr_rdata & 8'h92) == 8'h00)
        else $error("pins register reserved bit set");
    AST_TB_RSVD: assert property ($past(rd_c) && $past(sfr_req.addr) == 3'h4
        |-> (sfr_rdata & 8'hCC) == 8'h00)
        else $error("time base reserved bit set");
    AST_UNMAPPED: assert property ($past(rd_c) && $past(sfr_req.addr) > 3'h4
        |-> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    CV_IRQ: cover property (irq_req);
    CV_PIN: cover property ($rose(irq_pending[0]));
    CV_UNMAP: cover property (rd_c && sfr_req.addr == 3'h7);
endmodule // irqfe_regs_checker
bind irqfe_regs irqfe_regs_checker u_chk (.clk(clk), .rst(rst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .ext_pin_zero(ext_pin_zero), .ext_pin_one(ext_pin_one),
    .src_evt(src_evt), .irq_pending(irq_pending), .irq_req(irq_req));
`default_nettype wire

/* File: irqfe_pin_src.sv */
// external pin source model for the two interrupt pins
`timescale 1ns/1ps
`default_nettype none
module irqfe_pin_src (
    // commanded levels
    input  wire logic lvl_zero,
    input  wire logic lvl_one,
    // pins toward the device
    output logic      pin_zero,
    output logic      pin_one
);
    // pins are asynchronous: changes land mid-cycle
    assign #7 pin_zero = lvl_zero;
    assign #7 pin_one = lvl_one;
endmodule // irqfe_pin_src
`default_nettype wire

/* File: irqfe_regs_tb.sv */
// self-checking testbench for the interrupt flag and enable registers
`timescale 1ns/1ps
`default_nettype none
module irqfe_regs_tb;
    import irqfe_pkg::*;
    logic           clk = 1'b0, rst = 1'b1, lv0 = 1'b0, lv1 = 1'b0, rd_d = 1'b0;
    logic           pin0, pin1, irq_req;
    irqfe_sfr_req_t req = '0;
    irqfe_evt_t     evt = '0;
    logic [7:0]     rdata, v, f;
    logic [2:0]     ra;
    logic [11:0]    pend;
    logic [7:0]     expq[$];
    logic [7:0]     msk[5] = '{8'h0F, 8'h6D, 8'hFF, 8'hFF, 8'h33};
    int             failures = 0, n_compared = 0;
    always #12.5 clk = ~clk;
    irqfe_pin_src pins (.lvl_zero(lv0), .lvl_one(lv1), .pin_zero(pin0), .pin_one(pin1));
    irqfe_regs dut (.clk(clk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata),
        .ext_pin_zero(pin0), .ext_pin_one(pin1), .src_evt(evt), .irq_pending(pend),
        .irq_req(irq_req));
    task automatic cmp_rd(logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] read data expected %h seen %h", exp, got);
        end
    endtask
    task automatic cmp_irq(logic exp);
        @(negedge clk);
        n_compared++;
        if (irq_req !== exp) begin
            failures++;
            $display("[FAIL] irq_req expected %b seen %b", exp, irq_req);
        end
    endtask
    task automatic cmp_pend(logic [11:0] exp);
        @(negedge clk);
        n_compared++;
        if (pend !== exp) begin
            failures++;
            $display("[FAIL] irq_pending expected %h seen %h", exp, pend);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(logic [2:0] a, logic [7:0] e);
        @(posedge clk);
        req <= '{1'b1, 1'b0, 1'b1, a, 8'h00};
        expq.push_back(e);
        @(posedge clk);
        req <= '0;
    endtask
    task automatic pulse(int i);
        @(posedge clk);
        evt <= irqfe_evt_t'(10'h001 << i);
        @(posedge clk);
        evt <= '0;
    endtask
    task automatic test_done;
        if (expq.size() != 0) begin
            failures++;
            $display("[FAIL] read queue expected 0 seen %0d", expq.size());
        end
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==========================================
    // monitor: read data lands one cycle after the read
    always @(posedge clk) rd_d <= req.sel & req.rd;
    always @(negedge clk) begin
        if (rd_d && expq.size() > 0) begin
            cmp_rd(expq.pop_front(), rdata);
        end else if (rd_d) begin
            failures++;
            $display("[FAIL] read queue expected entry seen empty");
        end
    end
    initial begin
        for (int c = 0; c < 20000; c++) @(posedge clk);
        failures++;
        $display("[FAIL] run length expected end seen limit");
        test_done;
    end
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'hd935_f587));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
        $display("test reset values done");
        for (int a = 0; a < 5; a++) begin
            wr(a[2:0], 8'hFF);
            rd(a[2:0], msk[a]);
            if (a == 1) cmp_irq(1'b1);
            if (a == 1) cmp_pend(12'h003);
            wr(a[2:0], 8'h00);
        end
        for (int a = 2; a < 4; a++) begin
            v = 8'($urandom);
            wr(a[2:0], v);
            rd(a[2:0], v);
            wr(a[2:0], 8'h00);
        end
        $display("test access masks done");
        wr(3'h1, 8'h01);
        for (int i = 0; i < 10; i++) begin
            ra = (i > 5) ? 3'h2 : (i > 1) ? 3'h3 : 3'h4;
            f = 8'h01 << ((i > 5) ? i - 2 : (i > 1) ? i + 2 : i + 4);
            pulse(i);
            cmp_irq(1'b0);
            cmp_pend(12'h000);
            rd(ra, f);
            wr(ra, f | (f >> 4));
            cmp_irq(1'b1);
            cmp_pend(12'h001 << ((i > 5) ? i - 4 : (i > 1) ? i + 4 : i + 10));
            wr(ra, 8'h00);
            cmp_irq(1'b0);
        end
        wr(3'h1, 8'h00);
        wr(3'h2, 8'h04);
        pulse(8);
        cmp_irq(1'b0);
        cmp_pend(12'h010);
        wr(3'h1, 8'h01);
        cmp_irq(1'b1);
        wr(3'h2, 8'h00);
        wr(3'h1, 8'h00);
        $display("test source flags done");
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 4; s++) begin
                wr(3'h0, 8'(s << (2 * p)));
                for (int e = 0; e < 2; e++) begin
                    if (p == 0) lv0 <= (e == 0);
                    else lv1 <= (e == 0);
                    repeat (5) @(posedge clk);
                    rd(3'h1, ((s >> e) & 1) ? (8'h20 << p) : 8'h00);
                    wr(3'h1, 8'h00);
                end
            end
        end
        $display("test pin edges done");
        wr(3'h1, 8'h6D);
        wr(3'h2, 8'hFF);
        cmp_irq(1'b1);
        cmp_pend(12'h03F);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        cmp_irq(1'b0);
        cmp_pend(12'h000);
        for (int a = 0; a < 5; a++) rd(a[2:0], 8'h00);
        $display("test mid-run reset done");
        repeat (3) @(posedge clk);
        test_done;
    end
endmodule // irqfe_regs_tb
`default_nettype wire
